// ==== hw/bsc_pkg.sv ====
/*
  Constants for the second buck regulator configuration register bank.
  Assumes the byte-wide register port of the device's control interface
  engine (address, write strobe, write data, read data).
*/
// Function
// - Low range codes 54..63 give 1.7500 V up to 1.9750 V in 25 mV steps.
// - High range codes 115..127 are reserved, no defined output voltage.
// - Decode five byte addresses 0x35..0x39: normal, standby, sleep, mode, configuration.
// - Normal set point bits 5:0 read/write, reset 0x00, used in normal state.
// - Normal bit 6 is read-only range bit, loaded only from fuse or test box.
// - Standby set point bits 5:0 read/write, reset 0x00, used in standby.
// - Sleep set point bits 5:0 read/write, reset 0x00, used in sleep.
// - Standby and sleep bit 6 are read-only copies of the range bit.
// - Bit 7 of all three set-point registers is unused and reads zero.
// - Mode bits 3:0 read/write switching mode; bits 4 and 7:6 unused.
// - Mode bit 5 read/write reset 0; sleep off when 0, pulse-frequency when 1.
// - Configuration bit 0 read/write reset 0; 0 high current limit, 1 low.
// - Configuration bits 3:2 frequency select reset 0; bit 1 read/write unused.
// - Configuration bits 5:4 phase clock select, read/write, reset 0.
// - Configuration bits 7:6 voltage ramp speed, read/write, reset 0.
// - Apply normal, standby or sleep set point per operating state, each independent.
package bsc_pkg;
  localparam logic [7:0] ADDR_NORMAL = 8'h35;
  localparam logic [7:0] ADDR_STANDBY = 8'h36;
  localparam logic [7:0] ADDR_SLEEP = 8'h37;
  localparam logic [7:0] ADDR_MODE = 8'h38;
  localparam logic [7:0] ADDR_CONF = 8'h39;

  localparam logic [5:0] RST_SETPOINT = 6'h00;
  localparam logic [3:0] RST_MODE = 4'h0;
  localparam logic RST_SLEEP_BEHAVIOUR = 1'b0;
  localparam logic [7:0] RST_CONF = 8'h00;

  localparam int SP_W = 6;
  localparam int RANGE_BIT = 6;
  localparam int MODE_SLEEP_BIT = 5;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 3;
  localparam int CONF_ILIM = 0;
  localparam int CONF_FREQ_LSB = 2;
  localparam int CONF_PHASE_LSB = 4;
  localparam int CONF_RAMP_LSB = 6;

  // Voltage decode in millivolts
  localparam logic [11:0] LOW_BASE_MV = 12'h190;
  localparam logic [11:0] LOW_STEP_MV = 12'h019;
  localparam logic [11:0] HIGH_BASE_MV = 12'h320;
  localparam logic [11:0] HIGH_STEP_MV = 12'h032;
  localparam logic [5:0] HIGH_LAST_CODE = 6'h32;

  typedef enum logic [1:0] {BSC_NORMAL, BSC_STANDBY, BSC_SLEEP} bsc_state_e;
endpackage

// ==== hw/bsc_setpoint_decode.sv ====
/*
  Turns the selected 7-bit set-point code into a target voltage in mV.
  Assumes the code is already registered; output is registered here.
*/
`timescale 1ns/1ps
`default_nettype none
module bsc_setpoint_decode (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] code,
  output logic [11:0] millivolt,
  output logic reserved
);
  import bsc_pkg::*;
  logic [11:0] mv_r, mv_nxt;
  logic res_r, res_nxt;
  logic [11:0] step;

  always_comb begin
    step = {6'h00, code[SP_W-1:0]};
    res_nxt = 1'b0;
    if (code[RANGE_BIT]) begin
      mv_nxt = 12'(HIGH_BASE_MV + step * HIGH_STEP_MV);
      if (code[SP_W-1:0] > HIGH_LAST_CODE) begin
        res_nxt = 1'b1;
        mv_nxt = 12'h000;
      end
    end else begin
      mv_nxt = 12'(LOW_BASE_MV + step * LOW_STEP_MV);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mv_r <= 12'h000;
      res_r <= 1'b0;
    end else begin
      mv_r <= mv_nxt;
      res_r <= res_nxt;
    end
  end

  assign millivolt = mv_r;
  assign reserved = res_r;
endmodule
`default_nettype wire

// ==== hw/bsc_setpoint_select.sv ====
/*
  Picks the set point that belongs to the present operating state.
  Assumes the state input comes from the device state machine on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module bsc_setpoint_select (
  input wire logic clk,
  input wire logic rst_n,
  input wire bsc_pkg::bsc_state_e opState,
  input wire logic [5:0] normalSp,
  input wire logic [5:0] standbySp,
  input wire logic [5:0] sleepSp,
  input wire logic rangeBit,
  output logic [6:0] activeCode
);
  import bsc_pkg::*;
  logic [6:0] code_r, code_nxt;

  always_comb begin
    case (opState)
      BSC_STANDBY: code_nxt = {rangeBit, standbySp};
      BSC_SLEEP: code_nxt = {rangeBit, sleepSp};
      default: code_nxt = {rangeBit, normalSp};
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) code_r <= 7'h00;
    else code_r <= code_nxt;
  end

  assign activeCode = code_r;
endmodule
`default_nettype wire

// ==== hw/bsc_config_regs.sv ====
/*
  Register bank for the second buck regulator: three set points, mode
  selector and configuration, on the control interface's byte register port.
  Assumes the protocol engine gives one-cycle write strobes on clk and
  samples read data combinationally from the address. The range bit comes
  from the fuse/test-box loader with a one-cycle load strobe on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module bsc_config_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regHit,
  input wire logic rangeLoad,
  input wire logic rangeValue,
  input wire bsc_pkg::bsc_state_e opState,
  output logic [6:0] activeCode,
  output logic [11:0] targetMillivolt,
  output logic targetReserved,
  output logic [3:0] switchingMode,
  output logic sleepBehaviour,
  output logic currentLimitLow,
  output logic [1:0] switchingFrequency,
  output logic [1:0] phaseClock,
  output logic [1:0] voltageRampSpeed,
  output logic regulatorOffInSleep
);
  import bsc_pkg::*;

  logic [5:0] normal_r, normal_nxt;
  logic [5:0] standby_r, standby_nxt;
  logic [5:0] sleep_r, sleep_nxt;
  logic range_r, range_nxt;
  logic [3:0] mode_r, mode_nxt;
  logic sleepBeh_r, sleepBeh_nxt;
  logic [7:0] conf_r, conf_nxt;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  always_comb begin
    normal_nxt = normal_r;
    standby_nxt = standby_r;
    sleep_nxt = sleep_r;
    range_nxt = range_r;
    mode_nxt = mode_r;
    sleepBeh_nxt = sleepBeh_r;
    conf_nxt = conf_r;
    // Range bit is never host writable; only the loader touches it
    if (rangeLoad) range_nxt = rangeValue;
    if (regWrite) begin
      if (hit(regAddr, ADDR_NORMAL)) normal_nxt = regWdata[SP_W-1:0];
      if (hit(regAddr, ADDR_STANDBY)) standby_nxt = regWdata[SP_W-1:0];
      if (hit(regAddr, ADDR_SLEEP)) sleep_nxt = regWdata[SP_W-1:0];
      if (hit(regAddr, ADDR_MODE)) begin
        mode_nxt = regWdata[MODE_MSB:MODE_LSB];
        sleepBeh_nxt = regWdata[MODE_SLEEP_BIT];
      end
      if (hit(regAddr, ADDR_CONF)) conf_nxt = regWdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      normal_r <= RST_SETPOINT;
      standby_r <= RST_SETPOINT;
      sleep_r <= RST_SETPOINT;
      range_r <= 1'b0;
      mode_r <= RST_MODE;
      sleepBeh_r <= RST_SLEEP_BEHAVIOUR;
      conf_r <= RST_CONF;
    end else begin
      normal_r <= normal_nxt;
      standby_r <= standby_nxt;
      sleep_r <= sleep_nxt;
      range_r <= range_nxt;
      mode_r <= mode_nxt;
      sleepBeh_r <= sleepBeh_nxt;
      conf_r <= conf_nxt;
    end
  end

  always_comb begin
    regRdata = 8'h00;
    regHit = 1'b1;
    case (regAddr)
      ADDR_NORMAL: regRdata = {1'b0, range_r, normal_r};
      ADDR_STANDBY: regRdata = {1'b0, range_r, standby_r};
      ADDR_SLEEP: regRdata = {1'b0, range_r, sleep_r};
      ADDR_MODE: regRdata = {2'b00, sleepBeh_r, 1'b0, mode_r};
      ADDR_CONF: regRdata = conf_r;
      default: regHit = 1'b0;
    endcase
  end

  // Field outputs go straight from the flops, but regulatorOffInSleep also gates on opState; encodings live elsewhere
  assign switchingMode = mode_r;
  assign sleepBehaviour = sleepBeh_r;
  assign currentLimitLow = conf_r[CONF_ILIM];
  assign switchingFrequency = conf_r[CONF_FREQ_LSB +: 2];
  assign phaseClock = conf_r[CONF_PHASE_LSB +: 2];
  assign voltageRampSpeed = conf_r[CONF_RAMP_LSB +: 2];
  assign regulatorOffInSleep = (opState == BSC_SLEEP) && !sleepBeh_r;

  bsc_setpoint_select u_select (
    .clk(clk),
    .rst_n(rst_n),
    .opState(opState),
    .normalSp(normal_r),
    .standbySp(standby_r),
    .sleepSp(sleep_r),
    .rangeBit(range_r),
    .activeCode(activeCode)
  );

  bsc_setpoint_decode u_decode (
    .clk(clk),
    .rst_n(rst_n),
    .code(activeCode),
    .millivolt(targetMillivolt),
    .reserved(targetReserved)
  );
endmodule
`default_nettype wire

// ==== bench/bsc_config_regs_asserts.sv ====
/* Port checker for bsc_config_regs.
   Bound to every instance; sees only the top ports. */
`timescale 1ns/1ps
`default_nettype none
module bsc_config_regs_asserts
  import bsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regHit,
  input wire logic rangeLoad,
  input wire bsc_pkg::bsc_state_e opState,
  input wire logic [6:0] activeCode,
  input wire logic [11:0] targetMillivolt,
  input wire logic targetReserved,
  input wire logic [3:0] switchingMode,
  input wire logic sleepBehaviour,
  input wire logic currentLimitLow,
  input wire logic [1:0] switchingFrequency,
  input wire logic [1:0] phaseClock,
  input wire logic [1:0] voltageRampSpeed,
  input wire logic regulatorOffInSleep
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_unmapped_reads_zero: assert property (!regHit |-> regRdata == 8'h00)
    else $error("unmapped read not zero");
  chk_hit_window: assert property (
    regHit == (regAddr >= ADDR_NORMAL && regAddr <= ADDR_CONF))
    else $error("hit decode wrong");
  chk_setpoint_bit_seven: assert property (
    regHit && regAddr < ADDR_MODE |-> !regRdata[7])
    else $error("set point bit 7 set");
  // Range reg leads activeCode by a cycle, so skip the cycle after a load
  chk_range_copy_match: assert property (
    regHit && regAddr < ADDR_MODE && !$past(rangeLoad) |-> regRdata[6] == activeCode[6])
    else $error("range copy differs");
  chk_mode_fields_out: assert property (regWrite && regAddr == ADDR_MODE |=>
    switchingMode == $past(regWdata[3:0]) && sleepBehaviour == $past(regWdata[5]))
    else $error("mode fields wrong");
  chk_conf_fields_out: assert property (regWrite && regAddr == ADDR_CONF |=>
    {voltageRampSpeed, phaseClock, switchingFrequency, currentLimitLow}
    == {$past(regWdata[7:2]), $past(regWdata[0])})
    else $error("conf fields wrong");
  chk_off_in_sleep: assert property (
    regulatorOffInSleep == (opState == BSC_SLEEP && !sleepBehaviour))
    else $error("sleep off wrong");
  chk_normal_code_sel: assert property (
    regWrite && regAddr == ADDR_NORMAL && opState == BSC_NORMAL
    ##1 opState == BSC_NORMAL && !(regWrite && regAddr == ADDR_NORMAL)
    |=> activeCode[5:0] == $past(regWdata[5:0], 2))
    else $error("normal code not applied");
  chk_top_low_code: assert property (
    activeCode == 7'h3f |=> targetMillivolt == 12'h7b7 && !targetReserved)
    else $error("code 63 decode wrong");
  chk_reserved_high: assert property (activeCode[6] && activeCode[5:0] >= 6'h36 |=>
    targetReserved && targetMillivolt == 12'h000)
    else $error("reserved code decoded");
  cov_mode_write: cover property (regWrite && regAddr == ADDR_MODE);
  cov_reserved: cover property (targetReserved);
  cov_off_sleep: cover property (regulatorOffInSleep);
endmodule
bind bsc_config_regs bsc_config_regs_asserts u_chk (.*);
`default_nettype wire

// ==== bench/bsc_host_model.sv ====
/* Host side of the register port: byte writes and reads.
   Drives at the falling edge; the caller picks the codes. */
`timescale 1ns/1ps
`default_nettype none
module bsc_host_model (
  input wire logic clk,
  input wire logic [7:0] regRdata,
  output logic [7:0] regAddr = 8'h00,
  output logic regWrite = 1'b0,
  output logic [7:0] regWdata = 8'h00
);
  // Low current limit only written where no 2.5 A load is assumed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(posedge clk);
  endtask
  task automatic idle();
    @(negedge clk);
    regWrite = 1'b0;
    regWdata = ~regWdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regWrite = 1'b0;
    regAddr = a;
    @(posedge clk);
    d = regRdata;
  endtask
endmodule
`default_nettype wire

// ==== bench/test_buck_two_setpoint_config_regs.sv ====
/* Self-checking bench for bsc_config_regs with the host model.
   Range load and operating state come from the bench. */
`timescale 1ns/1ps
`default_nettype none
module test_buck_two_setpoint_config_regs;
  import bsc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rangeLoad = 1'b0;
  logic rangeValue = 1'b0;
  bsc_state_e opState = BSC_NORMAL;
  logic [7:0] regAddr, regWdata, regRdata;
  logic regWrite, regHit, targetReserved, sleepBehaviour, currentLimitLow, regulatorOffInSleep;
  logic [6:0] activeCode;
  logic [11:0] targetMillivolt;
  logic [3:0] switchingMode;
  logic [1:0] switchingFrequency, phaseClock, voltageRampSpeed;
  int nMismatch = 0;
  int totalChecks = 0;
  bsc_config_regs dut (.*);
  bsc_host_model host (.*);
  always #20 clk = ~clk;
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    check(12'(d), 12'(exp));
    check(12'(regHit), 12'(a >= ADDR_NORMAL && a <= ADDR_CONF));
  endtask
  task automatic settle();
    host.idle();
    repeat (2) @(negedge clk);
  endtask
  task automatic tReset();
    for (int a = 8'h35; a <= 8'h39; a++) begin
      rc(8'(a), 8'h00);
    end
  endtask
  task automatic tMidReset();
    // Reset in mid-run must clear host fields and the loaded range bit
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    tReset();
  endtask
  task automatic tRw();
    logic [7:0] exp [7] = '{8'h00, 8'h3f, 8'h3f, 8'h3f, 8'h2f, 8'hff, 8'h00};
    for (int i = 0; i < 7; i++) host.wr(8'h34 + 8'(i), 8'hff);
    host.idle();
    check(12'({switchingMode, sleepBehaviour}), 12'h01f);
    check(12'({voltageRampSpeed, phaseClock, switchingFrequency}), 12'h03f);
    check(12'(currentLimitLow), 12'h001);
    for (int i = 0; i < 7; i++) rc(8'h34 + 8'(i), exp[i]);
  endtask
  task automatic tStates();
    bsc_state_e s [3] = '{BSC_NORMAL, BSC_STANDBY, BSC_SLEEP};
    logic [11:0] mv [3] = '{12'h6d6, 12'h7b7, 12'h320};
    host.wr(ADDR_NORMAL, 8'h36);
    host.wr(ADDR_SLEEP, 8'h10);
    settle();
    for (int i = 0; i < 3; i++) begin
      opState = s[i];
      repeat (2) @(negedge clk);
      check(targetMillivolt, mv[i]);
    end
    check(12'(regulatorOffInSleep), 12'h000);
    host.wr(ADDR_MODE, 8'h00);
    host.idle();
    check(12'(regulatorOffInSleep), 12'h001);
    opState = BSC_NORMAL;
  endtask
  task automatic tRange();
    // Load strobe and host write share one edge; both must take
    fork
      host.wr(ADDR_NORMAL, 8'h32);
      begin
        @(negedge clk);
        rangeLoad = 1'b1;
        rangeValue = 1'b1;
        host.idle();
        rangeLoad = 1'b0;
        rangeValue = 1'b0;
      end
    join
    settle();
    check(targetMillivolt, 12'hce4);
    check(12'(activeCode), 12'h072);
    rc(ADDR_NORMAL, 8'h72);
    rc(ADDR_STANDBY, 8'h7f);
    rc(ADDR_SLEEP, 8'h50);
    host.wr(ADDR_NORMAL, 8'h36);
    settle();
    check({targetReserved, targetMillivolt[10:0]}, 12'h800);
  endtask
  task automatic wrapUp();
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    tReset();
    tRw();
    tStates();
    tRange();
    tMidReset();
    wrapUp();
  end
  // Watchdog so a stuck task cannot hang the run
  initial begin
    repeat (5000) @(posedge clk);
    nMismatch++;
    wrapUp();
  end
endmodule
`default_nettype wire
